// >>> dv/core_fw_model.sv
`timescale 1ns/10ps
module core_fw_model
	import enclave_gate_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        res_valid_q,
	input  wire logic [31:0] res_a_q,
	output logic             query_valid,
	output logic [31:0]      query_leaf,
	output logic [31:0]      query_subleaf,
	output logic             leaf_decode,
	output logic             optin_wr,
	output logic [31:0]      optin_wdata,
	output logic             sec_wr
);
	initial begin
		query_valid = 1'b0;
		query_leaf = 32'h0;
		query_subleaf = 32'h0;
		leaf_decode = 1'b0;
		optin_wr = 1'b0;
		optin_wdata = 32'h0;
		sec_wr = 1'b0;
	end

	// one strobe set per falling edge, all others low
	task automatic strobe(input logic q, input logic l, input logic o,
		input logic s);
		@(negedge clk_sys);
		query_valid = q;
		leaf_decode = l;
		optin_wr = o;
		sec_wr = s;
	endtask

	task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
		strobe(1'b1, 1'b0, 1'b0, 1'b0);
		query_leaf = leaf;
		query_subleaf = sub;
	endtask

	task automatic decode();
		strobe(1'b0, 1'b1, 1'b0, 1'b0);
	endtask

	// firmware opt-in write; the test also calls it after reset with no sections set up
	task automatic optin(input logic [31:0] d);
		strobe(1'b0, 1'b0, 1'b1, 1'b0);
		optin_wdata = d;
	endtask

	// pool scan from sub-leaf 2 up to first invalid type, or until 8 valid sub-leaves are counted
	task automatic scan(output int n);
		n = 0;
		do begin
			query(LEAF_ENCLAVE, SUBLEAF_POOL0 + 32'(n));
			strobe(1'b0, 1'b0, 1'b0, 1'b0);
			if (res_valid_q === 1'b1 && res_a_q[3:0] !== 4'h0) begin
				n++;
			end
		end while (res_a_q[3:0] !== 4'h0 && n < 8);
	endtask
endmodule

// >>> dv/test_enclave_feature_gate.sv
`timescale 1ns/10ps
module test_enclave_feature_gate
	import enclave_gate_pkg::*;
;
	logic               clk_sys = 1'b0;
	logic               srst = 1'b1;
	logic               query_thread = 1'b0;
	logic               leaf_thread = 1'b0;
	logic [1:0]         sec_idx = 2'h0;
	logic [39:0]        sec_base = 40'h0;
	logic [39:0]        sec_size = 40'h0;
	logic [3:0]         sec_prot = 4'h0;
	logic               query_valid, leaf_decode, optin_wr, sec_wr;
	logic [31:0]        query_leaf, query_subleaf, optin_wdata;
	logic               res_valid_q, verdict_valid_q, opted_in_q;
	logic [31:0]        res_a_q, res_b_q, res_c_q, res_d_q, optin_rdata_q;
	logic               optin_wr_fault_q, sec_wr_fault_q;
	gate_verdict_t      verdict_q;
	logic [127:0]       res_exp[$];
	gate_verdict_t      ver_exp[$];
	logic [127:0]       sw[3];
	logic [3:0]         pr[3] = '{4'h1, 4'h2, 4'h5};
	logic [31:0]        rng = 32'h9e07;
	int                 n_mismatch = 0;
	int                 samples_checked = 0;
	int                 n;

	enclave_feature_gate #(.THREAD_SUPPORT(2'b01)) i_enclave_feature_gate (
		.clk_sys(clk_sys), .srst(srst), .query_valid(query_valid),
		.query_thread(query_thread), .query_leaf(query_leaf),
		.query_subleaf(query_subleaf), .res_valid_q(res_valid_q),
		.res_a_q(res_a_q), .res_b_q(res_b_q), .res_c_q(res_c_q),
		.res_d_q(res_d_q), .optin_wr(optin_wr), .optin_wdata(optin_wdata),
		.optin_rdata_q(optin_rdata_q), .optin_wr_fault_q(optin_wr_fault_q),
		.opted_in_q(opted_in_q), .sec_wr(sec_wr), .sec_idx(sec_idx),
		.sec_base(sec_base), .sec_size(sec_size), .sec_prot(sec_prot),
		.sec_wr_fault_q(sec_wr_fault_q), .leaf_decode(leaf_decode),
		.leaf_thread(leaf_thread), .verdict_valid_q(verdict_valid_q),
		.verdict_q(verdict_q));

	core_fw_model i_core_fw_model (
		.clk_sys(clk_sys), .res_valid_q(res_valid_q), .res_a_q(res_a_q),
		.query_valid(query_valid), .query_leaf(query_leaf),
		.query_subleaf(query_subleaf), .leaf_decode(leaf_decode),
		.optin_wr(optin_wr), .optin_wdata(optin_wdata), .sec_wr(sec_wr));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic ask(input logic [31:0] leaf, input logic [31:0] sub,
		input logic t, input logic [127:0] e);
		i_core_fw_model.query(leaf, sub);
		query_thread = t;
		res_exp.push_back(e);
	endtask

	task automatic gate(input logic t, input gate_verdict_t v);
		i_core_fw_model.decode();
		leaf_thread = t;
		ver_exp.push_back(v);
	endtask

	task automatic idle(input int k);
		repeat (k) i_core_fw_model.strobe(1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic rst(input int k);
		idle(1);
		srst = 1'b1;
		idle(k);
		srst = 1'b0;
	endtask

	// results checked in order of request
	always @(negedge clk_sys) begin
		if (res_valid_q === 1'b1) begin
			if (res_exp.size() == 0) check(128'h1, 128'h0);
			else check({res_a_q, res_b_q, res_c_q, res_d_q},
				res_exp.pop_front());
		end
		if (verdict_valid_q === 1'b1) begin
			if (ver_exp.size() == 0) check(128'h1, 128'h0);
			else check(128'(verdict_q),
				128'(ver_exp.pop_front()));
		end
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		rst(16);
		check(128'(optin_rdata_q), 128'h0);
		ask(LEAF_FEATURES, 32'h0, 1'b0, {32'h0, 32'h4, 64'h0});
		ask(LEAF_ENCLAVE, SUBLEAF_CAPS, 1'b0,
			{32'h3, 32'h0, 32'h0, 32'h0000_241f});
		ask(LEAF_ENCLAVE, SUBLEAF_ATTR, 1'b0, {32'h3, 96'h0});
		ask(LEAF_ENCLAVE, SUBLEAF_POOL0, 1'b0, 128'h0);
		ask(32'h5, 32'h0, 1'b0, 128'h0);
		ask(LEAF_ENCLAVE, SUBLEAF_CAPS, 1'b1, 128'h0);
		gate(1'b1, GATE_UD);
		gate(1'b0, GATE_GP);
		for (int i = 0; i < 3; i++) begin
			i_core_fw_model.strobe(1'b0, 1'b0, 1'b0, 1'b1);
			sec_idx = 2'(i);
			sec_base = {8'(xs()), xs()};
			sec_size = {8'(xs()), xs()};
			sec_prot = pr[i];
			sw[i] = (i == 2) ? 128'h0 : {sec_base[19:0], 8'h0,
				POOL_TYPE_SECTION, 12'h0, sec_base[39:20], sec_size[19:0],
				8'h0, pr[i], 12'h0, sec_size[39:20]};
		end
		i_core_fw_model.optin(xs() | 32'h0004_0001);
		idle(1);
		check(128'(optin_rdata_q), 128'h0004_0001);
		idle(1);
		check(128'(opted_in_q), 128'h1);
		ask(LEAF_FEATURES, 32'h0, 1'b0, {32'h0, 32'h4, 64'h0});
		ask(LEAF_FEATURES, 32'h0, 1'b0, {32'h0, 32'h4, 64'h0});
		for (int i = 0; i < 3; i++) res_exp.push_back(sw[i]);
		i_core_fw_model.scan(n);
		check(128'(n), 128'h2);
		gate(1'b0, GATE_EXEC);
		gate(1'b1, GATE_UD);
		i_core_fw_model.optin(32'h0);
		idle(1);
		check({optin_wr_fault_q, optin_rdata_q}, {1'b1, 32'h0004_0001});
		i_core_fw_model.strobe(1'b0, 1'b0, 1'b0, 1'b1);
		idle(1);
		check(128'(sec_wr_fault_q), 128'h1);
		rst(2);
		i_core_fw_model.optin(32'h1);
		idle(2);
		gate(1'b0, GATE_GP);
		rst(2);
		i_core_fw_model.optin(32'h0004_0000);
		gate(1'b0, GATE_GP);
		i_core_fw_model.optin(32'h0004_0001);
		gate(1'b0, GATE_EXEC);
		idle(4);
		check(128'(res_exp.size() + ver_exp.size()), 128'h0);
		give_verdict();
	end
endmodule

// >>> verilog/enclave_feature_gate.sv
`timescale 1ns/10ps
// What the document requires
// [R01] support flag at feature leaf ENCLAVE_MISC_FEATURE_WORD bit 2
// [R02] enclave leaf answered when support flag set
// [R03] firmware sets opt-in before enabling resources; here section writes are taken only while the lock bit is clear
// [R04] opted in only when lock and opt-in set
// [R05] opt-in never changes reported support flag
// [R06] undefined fault, protection fault, or execute
// [R07] enclave leaf answers are per hardware thread
// [R08] configured device fills at least three sub-leaves
// [R09] sub-leaf 0 base/dynamic bits, reserved zero
// [R10] bits 5 and 6 report extra leaf groups
// [R11] sub-leaf 0 ENCLAVE_MISC_FEATURE_WORD holds save-area misc mask
// [R12] ENCLAVE_MAX_SIZE_WORD gives log2 maximum enclave sizes
// [R13] sub-leaf 1 reports settable attribute mask
// [R14] sub-leaf roles: caps, attributes, pool sections
// [R15] sub-leaf 2 reports pool with both sets
// [R16] software scans pool sub-leaves until invalid type
// [R17] invalid sub-leaf returns four zero words
// [R18] type 0 invalid, type 1 pool section
// [R19] base address bits split across ENCLAVE_CAPABILITY_LEAF_WORD_A/ENCLAVE_MISC_FEATURE_WORD
// [R20] section size bits split across ENCLAVE_CAPABILITY_RESERVED_WORD/ENCLAVE_MAX_SIZE_WORD
// [R21] protection code 1 full, 2 confidentiality
// [R22] gating uses current values without delay
module enclave_feature_gate
	import enclave_gate_pkg::*;
#(
	parameter int              THREADS         = 2,
	parameter logic [THREADS-1:0] THREAD_SUPPORT = {THREADS{1'b1}},
	parameter bit              CAP_BASE        = 1'b1,
	parameter bit              CAP_DYN         = 1'b1,
	parameter bit              CAP_CHILD       = 1'b0,
	parameter bit              CAP_CONFLICT    = 1'b0,
	parameter logic [31:0]     MISC_MASK       = 32'h0000_0000,
	parameter logic [7:0]      MAX_LOG2_LEGACY = 8'h1f,
	parameter logic [7:0]      MAX_LOG2_WIDE   = 8'h24,
	parameter logic [127:0]    ATTR_MASK       = 128'h3,
	parameter int              NUM_SECTIONS    = 4,
	localparam int             TW = (THREADS > 1) ? $clog2(THREADS) : 1,
	localparam int             IW = (NUM_SECTIONS > 1) ?
		$clog2(NUM_SECTIONS) : 1
) (
	input  wire logic                    clk_sys,
	input  wire logic                    srst,
	input  wire logic                    query_valid,
	input  wire logic [TW-1:0]           query_thread,
	input  wire logic [31:0]             query_leaf,
	input  wire logic [31:0]             query_subleaf,
	output logic                         res_valid_q,
	output logic      [31:0]             res_a_q,
	output logic      [31:0]             res_b_q,
	output logic      [31:0]             res_c_q,
	output logic      [31:0]             res_d_q,
	input  wire logic                    optin_wr,
	input  wire logic [31:0]             optin_wdata,
	output logic      [31:0]             optin_rdata_q,
	output logic                         optin_wr_fault_q,
	output logic                         opted_in_q,
	input  wire logic                    sec_wr,
	input  wire logic [IW-1:0]           sec_idx,
	input  wire logic [POOL_FIELD_W-1:0] sec_base,
	input  wire logic [POOL_FIELD_W-1:0] sec_size,
	input  wire logic [3:0]              sec_prot,
	output logic                         sec_wr_fault_q,
	input  wire logic                    leaf_decode,
	input  wire logic [TW-1:0]           leaf_thread,
	output logic                         verdict_valid_q,
	output gate_verdict_t                verdict_q
);

	// section table, written by firmware before lock
	logic [POOL_FIELD_W-1:0] sec_base_q [NUM_SECTIONS];
	logic [POOL_FIELD_W-1:0] sec_size_q [NUM_SECTIONS];
	logic [3:0]              sec_prot_q [NUM_SECTIONS];
	logic [NUM_SECTIONS-1:0] sec_valid_q;

	wire        opt_lock   = optin_rdata_q[OPTIN_LOCK_BIT];
	wire        opt_enable = optin_rdata_q[OPTIN_ENABLE_BIT];
	wire        opted_in   = opt_lock && opt_enable; // R04
	wire        both_sets  = CAP_BASE && CAP_DYN;

	// query decode
	wire        q_support  = THREAD_SUPPORT[query_thread]; // R07
	wire        q_feat     = query_leaf == LEAF_FEATURES &&
		query_subleaf == SUBLEAF_CAPS;
	wire        q_encl     = query_leaf == LEAF_ENCLAVE && q_support; // R02
	wire        q_caps     = q_encl && query_subleaf == SUBLEAF_CAPS; // R14
	wire        q_attr     = q_encl && query_subleaf == SUBLEAF_ATTR; // R14
	wire        q_pool     = q_encl && query_subleaf >= SUBLEAF_POOL0; // R14
	wire [31:0] pool_off   = query_subleaf - SUBLEAF_POOL0;
	wire        pool_range = pool_off < 32'(NUM_SECTIONS);
	wire [IW-1:0] pool_idx = pool_off[IW-1:0];
	wire        pool_hit   = q_pool && pool_range && both_sets &&
		opted_in && sec_valid_q[pool_idx]; // R15

	// sub-leaf 0 words
	wire [31:0] caps_a = (32'(CAP_BASE) << CAP_BASE_BIT) |
		(32'(CAP_DYN) << CAP_DYN_BIT) |
		(32'(CAP_CHILD) << CAP_CHILD_BIT) |
		(32'(CAP_CONFLICT) << CAP_CONFLICT_BIT); // R09 R10
	wire [31:0] caps_b = MISC_MASK; // R11
	wire [31:0] caps_c = 32'h0000_0000; // R09
	wire [31:0] caps_d = (32'(MAX_LOG2_LEGACY) << LOG2_LEGACY_LSB) |
		(32'(MAX_LOG2_WIDE) << LOG2_WIDE_LSB); // R12

	// feature leaf word, support only
	wire [31:0] feat_b = 32'(q_support) << SUPPORT_BIT; // R01 R05

	wire [31:0] pool_a;
	wire [31:0] pool_b;
	wire [31:0] pool_c;
	wire [31:0] pool_d;

	pool_section_format u_pool_fmt (
		.present (pool_hit),
		.base    (sec_base_q[pool_idx]),
		.size    (sec_size_q[pool_idx]),
		.prot    (sec_prot_q[pool_idx]),
		.word_a  (pool_a),
		.word_b  (pool_b),
		.word_c  (pool_c),
		.word_d  (pool_d)
	);

	// result selection; anything unmatched is zero
	wire [31:0] res_a_d = q_caps ? caps_a :
		q_attr ? ATTR_MASK[31:0] : q_pool ? pool_a : 32'h0000_0000; // R08 R17
	wire [31:0] res_b_d = q_feat ? feat_b : q_caps ? caps_b :
		q_attr ? ATTR_MASK[63:32] : q_pool ? pool_b : 32'h0000_0000;
	wire [31:0] res_c_d = q_caps ? caps_c :
		q_attr ? ATTR_MASK[95:64] : q_pool ? pool_c : 32'h0000_0000;
	wire [31:0] res_d_d = q_caps ? caps_d :
		q_attr ? ATTR_MASK[127:96] : q_pool ? pool_d : 32'h0000_0000; // R13

	// opt-in register and section table writes
	wire        optin_take = optin_wr && !opt_lock; // R04
	wire        sec_take   = sec_wr && !opt_lock; // R03
	wire        sec_prot_ok = sec_prot == PROT_CONF_INTEG ||
		sec_prot == PROT_CONF_ONLY; // R21

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			res_valid_q <= 1'b0;
			res_a_q     <= 32'h0000_0000;
			res_b_q     <= 32'h0000_0000;
			res_c_q     <= 32'h0000_0000;
			res_d_q     <= 32'h0000_0000;
		end else begin
			res_valid_q <= query_valid;
			if (query_valid) begin
				res_a_q <= res_a_d;
				res_b_q <= res_b_d;
				res_c_q <= res_c_d;
				res_d_q <= res_d_d;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			optin_rdata_q    <= OPTIN_RESET;
			optin_wr_fault_q <= 1'b0;
			opted_in_q       <= 1'b0;
		end else begin
			if (optin_take) begin
				optin_rdata_q <= optin_wdata & OPTIN_WRITE_MASK;
			end
			optin_wr_fault_q <= optin_wr && opt_lock;
			opted_in_q       <= opted_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sec_valid_q    <= '0;
			sec_wr_fault_q <= 1'b0;
		end else begin
			if (sec_take) begin
				sec_valid_q[sec_idx] <= sec_prot_ok;
			end
			sec_wr_fault_q <= sec_wr && opt_lock;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sec_take) begin
			sec_base_q[sec_idx] <= sec_base;
			sec_size_q[sec_idx] <= sec_size;
			sec_prot_q[sec_idx] <= sec_prot;
		end
	end

	enclave_leaf_gate u_gate (
		.clk_sys         (clk_sys),
		.srst            (srst),
		.leaf_decode     (leaf_decode),
		.hw_support      (THREAD_SUPPORT[leaf_thread]),
		.opt_lock        (opt_lock),
		.opt_enable      (opt_enable),
		.verdict_valid_q (verdict_valid_q),
		.verdict_q       (verdict_q)
	);

	// checks
	sequence s_feat_query;
		query_valid && q_feat;
	endsequence

	sequence s_caps_query;
		query_valid && q_caps;
	endsequence

	sequence s_pool_query;
		query_valid && pool_hit;
	endsequence

	property p_support_flag;
		@(posedge clk_sys) disable iff (srst)
		s_feat_query |=> res_valid_q &&
			res_b_q == (32'(THREAD_SUPPORT[$past(query_thread)])
			<< SUPPORT_BIT);
	endproperty
	a_support_flag: assert property (p_support_flag) // R01
		else $error("feature leaf support flag wrong");

	property p_flag_ignores_optin;
		@(posedge clk_sys) disable iff (srst)
		s_feat_query ##1 (s_feat_query and $stable(query_thread))
			|=> $stable(res_b_q);
	endproperty
	a_flag_ignores_optin: assert property (p_flag_ignores_optin) // R05
		else $error("support flag moved with opt-in state");

	property p_caps_word;
		@(posedge clk_sys) disable iff (srst)
		s_caps_query |=> res_a_q[0] == CAP_BASE && res_a_q[1] == CAP_DYN &&
			res_a_q[4:2] == 3'h0 && res_a_q[31:7] == 25'h0 &&
			res_c_q == 32'h0000_0000;
	endproperty
	a_caps_word: assert property (p_caps_word) // R09
		else $error("capability word wrong");

	property p_caps_extra;
		@(posedge clk_sys) disable iff (srst)
		s_caps_query |=> res_a_q[5] == CAP_CHILD &&
			res_a_q[6] == CAP_CONFLICT && res_b_q == MISC_MASK;
	endproperty
	a_caps_extra: assert property (p_caps_extra) // R10
		else $error("extra leaf group bits wrong");

	property p_size_word;
		@(posedge clk_sys) disable iff (srst)
		s_caps_query |=> res_d_q[7:0] == MAX_LOG2_LEGACY &&
			res_d_q[15:8] == MAX_LOG2_WIDE && res_d_q[31:16] == 16'h0;
	endproperty
	a_size_word: assert property (p_size_word) // R12
		else $error("maximum size word wrong");

	property p_attr_words;
		@(posedge clk_sys) disable iff (srst)
		query_valid && q_attr |=> res_a_q == ATTR_MASK[31:0] &&
			res_d_q == ATTR_MASK[127:96];
	endproperty
	a_attr_words: assert property (p_attr_words) // R13
		else $error("attribute mask words wrong");

	property p_invalid_zero;
		@(posedge clk_sys) disable iff (srst)
		query_valid && q_pool && !pool_hit |=> res_a_q == 32'h0 &&
			res_b_q == 32'h0 && res_c_q == 32'h0 && res_d_q == 32'h0;
	endproperty
	a_invalid_zero: assert property (p_invalid_zero) // R17
		else $error("invalid sub-leaf not all zero");

	property p_pool_section;
		@(posedge clk_sys) disable iff (srst)
		s_pool_query |=> res_a_q[3:0] == POOL_TYPE_SECTION &&
			res_a_q[11:4] == 8'h0 &&
			(res_c_q[3:0] == PROT_CONF_INTEG ||
			res_c_q[3:0] == PROT_CONF_ONLY);
	endproperty
	a_pool_section: assert property (p_pool_section) // R18
		else $error("pool section descriptor wrong");

	property p_lock_holds;
		@(posedge clk_sys) disable iff (srst)
		optin_wr && opt_lock |=> $stable(optin_rdata_q) && optin_wr_fault_q;
	endproperty
	a_lock_holds: assert property (p_lock_holds) // R04
		else $error("locked opt-in register changed");

	property p_attr_mid;
		@(posedge clk_sys) disable iff (srst)
		query_valid && q_attr |=> res_b_q == ATTR_MASK[63:32] &&
			res_c_q == ATTR_MASK[95:64];
	endproperty
	a_attr_mid: assert property (p_attr_mid) // R13
		else $error("middle attribute mask words wrong");

	property p_optin_store;
		@(posedge clk_sys) disable iff (srst)
		optin_wr && !opt_lock |=>
			optin_rdata_q == ($past(optin_wdata) & OPTIN_WRITE_MASK);
	endproperty
	a_optin_store: assert property (p_optin_store) // R04
		else $error("opt-in write not stored");

	property p_opted_follow;
		@(posedge clk_sys) disable iff (srst)
		opt_lock && opt_enable |=> opted_in_q;
	endproperty
	a_opted_follow: assert property (p_opted_follow) // R04
		else $error("opted-in flag missing");

	property p_pool_nonzero;
		@(posedge clk_sys) disable iff (srst)
		s_pool_query |=> res_a_q != 32'h0000_0000 &&
			res_b_q[31:20] == 12'h000 && res_d_q[31:20] == 12'h000;
	endproperty
	a_pool_nonzero: assert property (p_pool_nonzero) // R08
		else $error("valid pool sub-leaf read as empty");

endmodule

// >>> verilog/enclave_gate_pkg.sv
package enclave_gate_pkg;

	// query leaves and sub-leaves
	localparam logic [31:0] LEAF_FEATURES  = 32'h0000_0007;
	localparam logic [31:0] LEAF_ENCLAVE   = 32'h0000_0012;
	localparam logic [31:0] SUBLEAF_CAPS   = 32'h0000_0000;
	localparam logic [31:0] SUBLEAF_ATTR   = 32'h0000_0001;
	localparam logic [31:0] SUBLEAF_POOL0  = 32'h0000_0002;

	// bit positions
	localparam int SUPPORT_BIT      = 2;
	localparam int OPTIN_LOCK_BIT   = 0;
	localparam int OPTIN_ENABLE_BIT = 18;
	localparam int CAP_BASE_BIT     = 0;
	localparam int CAP_DYN_BIT      = 1;
	localparam int CAP_CHILD_BIT    = 5;
	localparam int CAP_CONFLICT_BIT = 6;
	localparam int LOG2_LEGACY_LSB  = 0;
	localparam int LOG2_WIDE_LSB    = 8;

	// pool section descriptor fields
	localparam int POOL_FIELD_W = 40;
	localparam int POOL_LOW_W   = 20;
	localparam int POOL_RSVD_W  = 8;
	localparam int POOL_HIGH_PAD = 12;
	localparam logic [3:0] POOL_TYPE_INVALID = 4'h0;
	localparam logic [3:0] POOL_TYPE_SECTION = 4'h1;
	localparam logic [3:0] PROT_CONF_INTEG   = 4'h1;
	localparam logic [3:0] PROT_CONF_ONLY    = 4'h2;

	// opt-in register
	localparam logic [31:0] OPTIN_RESET = 32'h0000_0000;
	localparam logic [31:0] OPTIN_WRITE_MASK =
		(32'h1 << OPTIN_LOCK_BIT) | (32'h1 << OPTIN_ENABLE_BIT);

	typedef enum logic [1:0] {
		GATE_EXEC = 2'b00,
		GATE_UD   = 2'b01,
		GATE_GP   = 2'b11
	} gate_verdict_t;

endpackage

// >>> verilog/enclave_leaf_gate.sv
`timescale 1ns/10ps
module enclave_leaf_gate
	import enclave_gate_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          srst,
	input  wire logic          leaf_decode,
	input  wire logic          hw_support,
	input  wire logic          opt_lock,
	input  wire logic          opt_enable,
	output logic               verdict_valid_q,
	output gate_verdict_t      verdict_q
);

	gate_verdict_t verdict_d;

	// decision from current values, no added delay
	assign verdict_d = !hw_support ? GATE_UD :
		(opt_lock && opt_enable) ? GATE_EXEC : GATE_GP; // R06 R22

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			verdict_valid_q <= 1'b0;
			verdict_q       <= GATE_UD;
		end else begin
			verdict_valid_q <= leaf_decode;
			if (leaf_decode) begin
				verdict_q <= verdict_d;
			end
		end
	end

	property p_gate_ud;
		@(posedge clk_sys) disable iff (srst)
		leaf_decode && !hw_support |=> verdict_valid_q && verdict_q == GATE_UD;
	endproperty
	a_gate_ud: assert property (p_gate_ud) // R06
		else $error("missing undefined-opcode fault");

	property p_gate_gp;
		@(posedge clk_sys) disable iff (srst)
		leaf_decode && hw_support && !(opt_lock && opt_enable)
			|=> verdict_q == GATE_GP;
	endproperty
	a_gate_gp: assert property (p_gate_gp) // R04
		else $error("missing general-protection fault");

	property p_gate_exec;
		@(posedge clk_sys) disable iff (srst)
		leaf_decode && hw_support && opt_lock && opt_enable
			|=> verdict_valid_q && verdict_q == GATE_EXEC;
	endproperty
	a_gate_exec: assert property (p_gate_exec) // R22
		else $error("leaf not allowed with opt-in complete");

endmodule

// >>> verilog/pool_section_format.sv
`timescale 1ns/10ps
module pool_section_format
	import enclave_gate_pkg::*;
(
	input  wire logic                    present,
	input  wire logic [POOL_FIELD_W-1:0] base,
	input  wire logic [POOL_FIELD_W-1:0] size,
	input  wire logic [3:0]              prot,
	output logic      [31:0]             word_a,
	output logic      [31:0]             word_b,
	output logic      [31:0]             word_c,
	output logic      [31:0]             word_d
);

	wire [31:0] fmt_a = {base[POOL_LOW_W-1:0], {POOL_RSVD_W{1'b0}},
		POOL_TYPE_SECTION}; // R18 R19
	wire [31:0] fmt_b = {{POOL_HIGH_PAD{1'b0}},
		base[POOL_FIELD_W-1:POOL_LOW_W]}; // R19
	wire [31:0] fmt_c = {size[POOL_LOW_W-1:0], {POOL_RSVD_W{1'b0}},
		prot}; // R20 R21
	wire [31:0] fmt_d = {{POOL_HIGH_PAD{1'b0}},
		size[POOL_FIELD_W-1:POOL_LOW_W]}; // R20

	// absent section reads as all zero
	assign word_a = present ? fmt_a : 32'h0000_0000; // R17
	assign word_b = present ? fmt_b : 32'h0000_0000;
	assign word_c = present ? fmt_c : 32'h0000_0000;
	assign word_d = present ? fmt_d : 32'h0000_0000;

endmodule
